/* cpu_core_model.sv */
// CPU core model: takes each request after a short or long delay.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module cpu_core_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic req_i,
    input  wire logic slow_i,
    output logic      ack_o
);
    logic [2:0] wait_r;  // Cycles spent on the current request.
    logic       done_r;  // Request taken; wait until it drops.
    // One ack pulse per request, so a lingering request is not taken twice.
    always_ff @(posedge clk_i) begin
        ack_o <= 1'b0;
        if (rst_i || !req_i) begin
            wait_r <= 3'h0;
            done_r <= 1'b0;
        end else if (!done_r) begin
            if (wait_r >= (slow_i ? 3'h4 : 3'h1)) begin
                ack_o  <= 1'b1;
                done_r <= 1'b1;
            end else begin
                wait_r <= wait_r + 3'h1;
            end
        end
    end
endmodule

/* interrupt_priority_control.sv */
// Interrupt priority controller with an APB register slave.
//
// What this block does
// - Each source has a sticky request flag.
// - Each source has its own enable bit.
// - Each source has a three-bit priority.
// - Pending vector and level latched, readable.
// - Bit order follows vector order, source zero first.
// - Low CPU priority bits writable in status word.
// - Top CPU priority bit read-only to software.
// - Top bit concatenated above three low bits.
// - User interrupts blocked at top bit or 111.
// - Top bit means level above seven.
// - Nesting disable blocks software writes to low priority bits; a taken vector sets them to 111.
// - Divide, DMA and math trap cause bits.
// - Address, stack and clock-loss trap bits.
// - Alternate vector table select bit.
// - Read-only disable-instruction active status bit.
// - Edge polarity select for five external inputs.
// - Unused bits read zero, all reset zero.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "interrupt_priority_control_params.svh"

module interrupt_priority_control (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    ce_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [7:0]              paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    input  wire logic [`NUM_SRC-1:0]     periph_evt_i,
    input  wire logic [`NUM_EXT-1:0]     ext_pin_i,
    input  wire logic [`NUM_TRAPS-1:0]   trap_evt_i,
    input  wire logic                    trap_enter_i,
    input  wire logic                    trap_exit_i,
    input  wire logic                    cpu_ack_i,
    input  wire logic                    masking_instruction_active_i,
    output logic                         cpu_req_o,
    output logic [6:0]                   pending_vector_number_o,
    output logic [3:0]                   pending_level_o,
    output logic [3:0]                   cpu_level_o,
    output logic                         alternate_table_select_o,
    output logic                         irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    ////////////////////////////////////////////////////////////////////////

    logic [`NUM_SRC-1:0] request_flag_r;      // Sticky request flags.
    logic [`NUM_SRC-1:0] source_enable_r;     // Per-source enables.
    interrupt_priority_control_pkg::prio_t source_prio_r [`NUM_SRC];
    interrupt_priority_control_pkg::prio_t cpu_priority_low_r;
    logic                cpu_priority_top_bit_r;  // Set by trap entry.
    logic                nesting_disable_r;       // Blocks software writes to the low bits.
    logic [`NUM_TRAPS-1:0] trap_flag_r;           // Trap cause bits.
    logic                alt_table_r;             // Vector table select.
    logic [`NUM_EXT-1:0] ext_polarity_r;          // One means falling.
    interrupt_priority_control_pkg::vec_t   pend_vec_r;
    interrupt_priority_control_pkg::level_t pend_level_r;
    logic                cpu_req_r;               // Request to the CPU.
    logic [`IRQ_W-1:0]   irq_stat_r;              // Sticky event bits.
    logic [`IRQ_W-1:0]   irq_mask_r;              // Event enables.
    logic                irq_r;                   // Registered interrupt.
    logic [31:0]         prdata_r;                // Registered read data.
    logic                pready_r;                // Registered ready.
    logic                pslverr_r;               // Registered error.
    logic [`NUM_EXT-1:0] ext_meta_r;              // Synchroniser stage 1.
    logic [`NUM_EXT-1:0] ext_sync_r;              // Synchroniser stage 2.
    logic [`NUM_EXT-1:0] ext_prev_r;              // Previous synced level.

    logic [5:0]          idx;                     // Word index of access.
    logic                setup;                   // Setup cycle seen.
    logic                wr_en;                   // Write takes effect.
    logic                mapped;                  // Address is decoded.
    interrupt_priority_control_pkg::word_t wdata; // Low half of pwdata.
    interrupt_priority_control_pkg::word_t rdata; // Read mux output.
    interrupt_priority_control_pkg::level_t cpu_level;
    logic [`NUM_EXT-1:0] ext_edge;                // Active edge per input.
    logic [`NUM_SRC-1:0] src_set;                 // Flag set events.
    logic                user_blocked;            // CPU masks all users.
    logic                best_found;              // A request qualifies.
    logic [3:0]          best_idx;                // Winning source.
    interrupt_priority_control_pkg::prio_t best_prio;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.
    ////////////////////////////////////////////////////////////////////////

    // Writes land only in the access cycle whose ready is high.
    assign idx    = paddr_i[7:2];
    assign setup  = psel_i & ~penable_i;
    assign wr_en  = ce_i & psel_i & penable_i & pready_r & pwrite_i & mapped;
    assign wdata  = pwdata_i[15:0];

    // The full level is the top bit placed above the low three.
    assign cpu_level = {cpu_priority_top_bit_r, cpu_priority_low_r};

    // Any user source is masked when the top bit is set or the low bits
    // stand at their maximum.
    assign user_blocked = cpu_priority_top_bit_r
                        | (cpu_priority_low_r == `LEVEL_MAX_LOW);

    ////////////////////////////////////////////////////////////////////////
    // External input synchronisers and edge detection.
    ////////////////////////////////////////////////////////////////////////

    // Two flops bring the pins into the clock domain; a third holds the
    // previous synced level so that only the second stage feeds an edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_meta_r <= '0;
            ext_sync_r <= '0;
            ext_prev_r <= '0;
        end else if (ce_i) begin
            ext_meta_r <= ext_pin_i;
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
        end
    end

    // Polarity one picks the falling edge, zero the rising edge.
    assign ext_edge = (ext_polarity_r & ext_prev_r & ~ext_sync_r)
                    | (~ext_polarity_r & ~ext_prev_r & ext_sync_r);

    // External input k raises source k; source zero is input zero.
    assign src_set = periph_evt_i
                   | {{(`NUM_SRC-`NUM_EXT){1'b0}}, ext_edge};

    ////////////////////////////////////////////////////////////////////////
    // Per-source flag, enable and priority storage.
    ////////////////////////////////////////////////////////////////////////

    for (genvar s = 0; s < `NUM_SRC; s++) begin : g_src
        localparam logic [5:0] PRIO_IDX =
            6'(`IDX_PRIO0 + s / `PRIO_PER_REG);
        localparam int FLD = (s % `PRIO_PER_REG) * `PRIO_FIELD_W;

        // A hardware set wins over a software write of zero, so an event
        // that lands on the clearing write is kept.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                request_flag_r[s] <= 1'b0;
            end else if (ce_i) begin
                if (wr_en && idx == `IDX_FLAGS) begin
                    request_flag_r[s] <= wdata[s] | src_set[s];
                end else begin
                    request_flag_r[s] <= request_flag_r[s] | src_set[s];
                end
            end
        end

        // The enable bit of each source is written independently.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                source_enable_r[s] <= 1'b0;
            end else if (ce_i && wr_en && idx == `IDX_ENABLES) begin
                source_enable_r[s] <= wdata[s];
            end
        end

        // Four three-bit fields share a word, one per nibble.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                source_prio_r[s] <= '0;
            end else if (ce_i && wr_en && idx == PRIO_IDX) begin
                source_prio_r[s] <= wdata[FLD +: 3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending request search.
    ////////////////////////////////////////////////////////////////////////

    // Highest priority wins; on a tie the lower source, earlier in the
    // vector order, wins because the scan runs downward with >=.
    always_comb begin
        best_found = 1'b0;
        best_idx   = '0;
        best_prio  = '0;
        for (int k = `NUM_SRC - 1; k >= 0; k--) begin
            if (request_flag_r[k] && source_enable_r[k] &&
                ({1'b0, source_prio_r[k]} > cpu_level) &&
                !user_blocked &&
                (!best_found || source_prio_r[k] >= best_prio)) begin
                best_found = 1'b1;
                best_idx   = 4'(k);
                best_prio  = source_prio_r[k];
            end
        end
    end

    // The vector and level are latched while a request is pending and
    // held once it goes away, so software can still read the last one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_vec_r   <= '0;
            pend_level_r <= '0;
            cpu_req_r    <= 1'b0;
        end else if (ce_i) begin
            cpu_req_r <= best_found;
            if (best_found) begin
                pend_vec_r   <= `VEC_BASE + 7'(best_idx);
                pend_level_r <= {1'b0, best_prio};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // CPU priority level.
    ////////////////////////////////////////////////////////////////////////

    // The CPU taking a vector raises the level to the pending one, or to
    // the maximum when nesting is off; software may write it otherwise.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_priority_low_r <= '0;
        end else if (ce_i) begin
            if (cpu_ack_i) begin
                cpu_priority_low_r <= nesting_disable_r ? `LEVEL_MAX_LOW
                                                        : pend_level_r[2:0];
            end else if (wr_en && idx == `IDX_STATUS &&
                         !nesting_disable_r) begin
                cpu_priority_low_r <= wdata[`CPU_LOW_LSB +: 3];
            end
        end
    end

    // Only trap entry and exit move the top bit; no bus write reaches it,
    // so software can never mask a trap.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_priority_top_bit_r <= 1'b0;
        end else if (ce_i) begin
            if (trap_enter_i) begin
                cpu_priority_top_bit_r <= 1'b1;
            end else if (trap_exit_i) begin
                cpu_priority_top_bit_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Global and edge control words.
    ////////////////////////////////////////////////////////////////////////

    // Nesting disable is a plain read-write bit.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nesting_disable_r <= 1'b0;
        end else if (ce_i && wr_en && idx == `IDX_GLOBAL) begin
            nesting_disable_r <= wdata[`NEST_BIT];
        end
    end

    // Trap cause bits: oscillator, stack, address, math, DMA, divide, in
    // bits one to six. A trap in the write cycle wins over the write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trap_flag_r <= '0;
        end else if (ce_i) begin
            if (wr_en && idx == `IDX_GLOBAL) begin
                trap_flag_r <= wdata[`TRAP_LSB +: `NUM_TRAPS]
                             | trap_evt_i;
            end else begin
                trap_flag_r <= trap_flag_r | trap_evt_i;
            end
        end
    end

    // Table select and edge polarities are plain read-write fields.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alt_table_r    <= 1'b0;
            ext_polarity_r <= '0;
        end else if (ce_i && wr_en && idx == `IDX_EDGE) begin
            alt_table_r    <= wdata[`ALT_BIT];
            ext_polarity_r <= wdata[`NUM_EXT-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask.
    ////////////////////////////////////////////////////////////////////////

    // Status bits are sticky and cleared by writing one; a new event in
    // the same cycle as the clearing write keeps its bit set.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
        end else if (ce_i) begin
            irq_stat_r[`IRQ_TRAP_BIT] <= (|trap_evt_i) |
                (irq_stat_r[`IRQ_TRAP_BIT] &
                 ~(wr_en && idx == `IDX_IRQ_STAT &&
                   wdata[`IRQ_TRAP_BIT]));
            irq_stat_r[`IRQ_PEND_BIT] <= (best_found & ~cpu_req_r) |
                (irq_stat_r[`IRQ_PEND_BIT] &
                 ~(wr_en && idx == `IDX_IRQ_STAT &&
                   wdata[`IRQ_PEND_BIT]));
        end
    end

    // The mask is read-write; the output is high while any unmasked bit
    // is set, one cycle behind the status.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_r <= '0;
            irq_r      <= 1'b0;
        end else if (ce_i) begin
            if (wr_en && idx == `IDX_IRQ_MASK) begin
                irq_mask_r <= wdata[`IRQ_W-1:0];
            end
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux.
    ////////////////////////////////////////////////////////////////////////

    // Every bit not named here reads zero.
    always_comb begin
        rdata  = `REG_RESET;
        mapped = (paddr_i[1:0] == 2'b00);
        unique case (idx)
            `IDX_STATUS: rdata[`CPU_LOW_LSB +: 3] = cpu_priority_low_r;
            `IDX_CORE:   rdata[`CPU_TOP_BIT] = cpu_priority_top_bit_r;
            `IDX_GLOBAL: begin
                rdata[`NEST_BIT] = nesting_disable_r;
                rdata[`TRAP_LSB +: `NUM_TRAPS] = trap_flag_r;
            end
            `IDX_EDGE: begin
                rdata[`ALT_BIT]       = alt_table_r;
                rdata[`MASK_ACT_BIT]  = masking_instruction_active_i;
                rdata[`NUM_EXT-1:0]   = ext_polarity_r;
            end
            `IDX_FLAGS:   rdata = request_flag_r;
            `IDX_ENABLES: rdata = source_enable_r;
            `IDX_PENDING: begin
                rdata[6:0] = pend_vec_r;
                rdata[`PEND_LEVEL_LSB +: 4] = pend_level_r;
            end
            `IDX_IRQ_STAT: rdata[`IRQ_W-1:0] = irq_stat_r;
            `IDX_IRQ_MASK: rdata[`IRQ_W-1:0] = irq_mask_r;
            default: begin
                // Priority words sit between the enables and the pending
                // word; anything else is unmapped.
                if (idx >= `IDX_PRIO0 && idx < `IDX_PENDING) begin
                    for (int f = 0; f < `PRIO_PER_REG; f++) begin
                        rdata[f*`PRIO_FIELD_W +: 3] =
                            source_prio_r[(idx - `IDX_PRIO0) *
                                          `PRIO_PER_REG + f];
                    end
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer.
    ////////////////////////////////////////////////////////////////////////

    // Ready rises in the first access cycle and drops after it, so every
    // transfer takes exactly two cycles. Read data and error are captured
    // in the setup cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_r  <= 1'b0;
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end else if (ce_i) begin
            pready_r <= setup;
            if (setup) begin
                prdata_r  <= mapped ? {16'h0000, rdata} : '0;
                pslverr_r <= ~mapped;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    ////////////////////////////////////////////////////////////////////////

    assign prdata_o                 = prdata_r;
    assign pready_o                 = pready_r;
    assign pslverr_o                = pslverr_r;
    assign irq_o                    = irq_r;
    assign cpu_req_o                = cpu_req_r;
    assign pending_vector_number_o  = pend_vec_r;
    assign pending_level_o          = pend_level_r;
    assign cpu_level_o              = cpu_level;
    assign alternate_table_select_o = alt_table_r;

endmodule

/* interrupt_priority_control_chk.sv */
// Assertion checker bound to the interrupt priority controller.
`timescale 1ns/1ps
`include "interrupt_priority_control_params.svh"
////////////////////////////////////////////////////////////////
module prio_ctrl_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        trap_enter_i,
    input wire logic        cpu_req_o,
    input wire logic [6:0]  pending_vector_number_o,
    input wire logic [3:0]  pending_level_o,
    input wire logic [3:0]  cpu_level_o
);
    // All checks run on the one clock and pause in reset.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ready_next_a: assert property (psel_i && !penable_i |=> pready_o)
        else $error("ready late");
    ready_once_a: assert property (pready_o |=> !pready_o)
        else $error("ready held");
    upper_zero_a: assert property (pready_o |-> !prdata_o[31:16])
        else $error("upper half set");
    misalign_a: assert property (psel_i && !penable_i && paddr_i[1:0] != 0
        |=> pslverr_o && prdata_o == 0) else $error("misaligned taken");
    unmapped_a: assert property (psel_i && !penable_i
        && paddr_i[7:2] > `IDX_IRQ_MASK |=> pslverr_o) else $error("no err");
    top_set_a: assert property (trap_enter_i && ce_i
        |=> cpu_level_o[3]) else $error("top bit not set");
    req_qual_a: assert property (cpu_req_o
        |-> !$past(cpu_level_o[3])
        && pending_level_o[2:0] > $past(cpu_level_o[2:0]))
        else $error("request not above level");
    vec_range_a: assert property (cpu_req_o
        |-> !pending_level_o[3] && pending_vector_number_o >= `VEC_BASE
        && pending_vector_number_o < `VEC_BASE + `NUM_SRC)
        else $error("vector out of range");
endmodule
bind interrupt_priority_control prio_ctrl_chk u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .trap_enter_i(trap_enter_i), .cpu_req_o(cpu_req_o),
    .pending_vector_number_o(pending_vector_number_o),
    .pending_level_o(pending_level_o), .cpu_level_o(cpu_level_o));

/* interrupt_priority_control_params.svh */
// Constants for the interrupt priority controller: offsets, fields, sizes.
`ifndef INTERRUPT_PRIORITY_CONTROL_PARAMS_SVH
`define INTERRUPT_PRIORITY_CONTROL_PARAMS_SVH

// Register word indexes; the byte address is four times the index.
`define IDX_STATUS      6'h00
`define IDX_CORE        6'h01
`define IDX_GLOBAL      6'h02
`define IDX_EDGE        6'h03
`define IDX_FLAGS       6'h04
`define IDX_ENABLES     6'h05
`define IDX_PRIO0       6'h06
`define IDX_PENDING     6'h0a
`define IDX_IRQ_STAT    6'h0b
`define IDX_IRQ_MASK    6'h0c

// Sizes of the source array.
`define NUM_SRC         16
`define NUM_EXT         5
`define PRIO_PER_REG    4
`define NUM_PRIO_REGS   4
`define PRIO_FIELD_W    4

// Field positions in the status and core control words.
`define CPU_LOW_LSB     5
`define CPU_TOP_BIT     3

// Field positions in the global control word.
`define NEST_BIT        15
`define TRAP_LSB        1
`define NUM_TRAPS       6

// Field positions in the edge and vector control word.
`define ALT_BIT         15
`define MASK_ACT_BIT    14

// Field positions in the pending vector word.
`define PEND_LEVEL_LSB  8

// Vector number of source zero and the level forced by nesting disable.
`define VEC_BASE        7'h08
`define LEVEL_MAX_LOW   3'h7

// Bits of the interrupt status and mask words.
`define IRQ_TRAP_BIT    0
`define IRQ_PEND_BIT    1
`define IRQ_W           2

// Reset value of every register.
`define REG_RESET       16'h0000

`endif

/* interrupt_priority_control_pkg.sv */
// Types shared by the interrupt priority controller.
package interrupt_priority_control_pkg;
    typedef logic [2:0]  prio_t;   // Per-source priority, eight levels.
    typedef logic [3:0]  level_t;  // Full CPU priority level.
    typedef logic [6:0]  vec_t;    // Vector number.
    typedef logic [15:0] word_t;   // One register's data.
endpackage

/* tb_interrupt_priority_control.sv */
// Self-checking bench for the interrupt priority controller.
`timescale 1ns/1ps
`include "interrupt_priority_control_params.svh"
////////////////////////////////////////////////////////////////
module tb_interrupt_priority_control;
    logic        clk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0;
    logic        rdy, err, er, req, irq, ack, alt, t_in = 0, t_out = 0;
    logic        dis = 0, slow = 0, ce = 1;
    logic [7:0]  addr = 0;
    logic [31:0] wd = 0, rdat, q;
    logic [15:0] evt = 0;
    logic [5:0]  trap = 0;
    logic [4:0]  ext = 0;
    logic [6:0]  vec;
    logic [3:0]  plev, clev;
    int          err_count = 0, n_tests = 0, s, p, n;
    int          seed = 32'hbc1cc856;
    initial forever #2 clk_i = ~clk_i;
    interrupt_priority_control DUT (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(addr), .pwdata_i(wd), .prdata_o(rdat), .pready_o(rdy),
        .pslverr_o(err), .periph_evt_i(evt), .ext_pin_i(ext),
        .trap_evt_i(trap), .trap_enter_i(t_in), .trap_exit_i(t_out),
        .cpu_ack_i(ack), .masking_instruction_active_i(dis),
        .cpu_req_o(req), .pending_vector_number_o(vec),
        .pending_level_o(plev), .cpu_level_o(clev),
        .alternate_table_select_o(alt), .irq_o(irq));
    cpu_core_model CPU (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .slow_i(slow), .ack_o(ack));
    ////////////////////////////////////////////////////////////////
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; the spare edge first keeps transfers apart.
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        tick(1);
        psel <= 1;
        pwr  <= w;
        addr <= a;
        wd   <= d;
        tick(1);
        pen <= 1;
        do tick(1); while (rdy !== 1'b1);
        q = rdat;
        er = err;
        psel <= 0;
        pen  <= 0;
    endtask
    task automatic wr(input int i, input int d);
        apb(1, 8'(i * 4), d);
    endtask
    task automatic rd(input int i, input int e, input string nm);
        apb(0, 8'(i * 4), 0);
        chk(nm, q, e);
    endtask
    // Readback after writing all ones with the masking status active.
    function automatic int wmask(input int i);
        return i == 0 ? 'h00e0 : i == 2 ? 'h807e : i == 3 ? 'hc01f : 0;
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        tick(5);
        rst_i <= 0;
        for (int i = 0; i < 13; i++) rd(i, 0, "reset");
        apb(0, 8'h34, 0);
        chk("unmapped", er, 1);
        apb(1, 8'h01, 'hffff);
        chk("misaligned", er, 1);
        rd(0, 0, "bad write");
        dis <= 1;
        for (int i = 0; i < 4; i++) begin
            wr(i, 'hffff);
            rd(i, wmask(i), "access");
            chk("alt table", alt, i == 3);
            if (i == 2) begin
                wr(0, 'h00a0);
                rd(0, 0, "frozen level");
            end
            wr(i, 0);
        end
        dis <= 0;
        rd(3, 0, "disable status");
        $display("access test done");
        for (int b = 0; b < 6; b++) begin
            trap <= 6'h01 << b;
            tick(1);
            trap <= 0;
            rd(2, 2 << b, "trap cause");
            wr(2, 0);
        end
        ce <= 0;
        t_in <= 1;
        tick(1);
        ce <= 1;
        t_in <= 0;
        tick(1);
        chk("frozen", clev, 0);
        t_in <= 1;
        tick(1);
        t_in <= 0;
        tick(1);
        chk("level", clev, 8);
        rd(1, 8, "core");
        t_out <= 1;
        tick(1);
        t_out <= 0;
        rd(1, 0, "core");
        $display("trap test done");
        // Each external input on a rising, then a falling edge.
        for (int k = 0; k < 5; k++) begin
            ext[k] <= 1;
            tick(6);
            rd(4, 1 << k, "rise");
            wr(4, 0);
            wr(3, 1 << k);
            ext[k] <= 0;
            tick(6);
            rd(4, 1 << k, "fall");
            wr(4, 0);
            wr(3, 0);
        end
        $display("edge test done");
        // Random source and priority; both extremes come first.
        for (int i = 0; i < 10; i++) begin
            s = $random(seed) & 15;
            p = 1 + ($random(seed) & 255) % 7;
            if (i < 2) s = i ? 0 : 15;
            if (i < 2) p = i ? 1 : 7;
            slow <= s[0];
            wr(12, s & 2);
            wr(11, 3);
            wr(6 + s / 4, p << (4 * (s % 4)));
            evt[s] <= 1;
            tick(1);
            evt[s] <= 0;
            tick(4);
            chk("disabled", req, 0);
            rd(4, 1 << s, "flag");
            wr(5, 1 << s);
            n = 0;
            while (req !== 1'b1 && n < 20) begin
                tick(1);
                n++;
            end
            chk("request", req, 1);
            chk("vector", vec, `VEC_BASE + s);
            chk("plevel", plev, p);
            rd(10, p << 8 | `VEC_BASE + s, "pending");
            tick(3);
            chk("irq", irq, s[1]);
            tick(6);
            rd(0, p << 5, "acked");
            wr(4, 0);
            wr(0, 0);
            wr(6 + s / 4, 0);
            wr(5, 0);
            wr(11, 3);
            rd(11, 0, "irq clear");
        end
        $display("request test done");
        final_report;
    end
    // Cuts a hang short well past the expected run length.
    initial begin
        tick(20000);
        err_count++;
        final_report;
    end
endmodule
